// ---- pkg/cfp_defs.svh ----
// Constants for the fetch port and coprocessor handshake.
// Assumes inclusion by the package, the checker and the bench.
`ifndef CFP_DEFS_SVH
`define CFP_DEFS_SVH
// ----------------------------------------
// Vectors and encodings
// ----------------------------------------
`define CFP_UNDEF_VEC 32'h0000_0004
`define CFP_UNDEF_VEC2 32'h0000_0008
`define CFP_UNDEF_VEC3 32'h0000_000C
`define CFP_RESET_VEC 32'h0000_0000
`define CFP_MODE_USER 5'h10
`define CFP_MODE_UND 5'h1B
`define CFP_MODE_SVC 5'h13
`define CFP_HS_ABSENT 2'h0
`define CFP_HS_WAIT 2'h1
`define CFP_HS_GO 2'h2
`define CFP_HS_LAST 2'h3
`endif

// ---- pkg/cfp_pkg.sv ----
// Types shared by the core fetch end and the memory/coprocessor end.
// Assumes cfp_defs.svh on the include path.
`include "cfp_defs.svh"
package cfp_pkg;
  typedef enum logic [1:0] {
    CFP_HS_ABSENT_E = 2'h0,
    CFP_HS_WAIT_E = 2'h1,
    CFP_HS_GO_E = 2'h2,
    CFP_HS_LAST_E = 2'h3
  } cfp_hs_t;
  typedef enum logic [1:0] {
    CFP_CYC_I, CFP_CYC_N, CFP_CYC_S
  } cfp_cyc_t;
endpackage

// ---- pkg/cfp_if.sv ----
// Interface joining the core fetch port and its memory/coprocessor side.
// Assumes one clock and synchronous reset driven by the bench.
`timescale 1ns/10ps
interface cfp_if;
  logic [31:1] fetch_address;
  logic fetch_request_n;
  logic fetch_sequential;
  logic [4:0] fetch_mode;
  logic fetch_privileged;
  logic compressed_state;
  logic cond_pass;
  logic late_cancel_a;
  logic data_request_n;
  logic data_sequential;
  logic state_advance_out;
  logic [31:0] fetch_data;
  logic fetch_abort;
  logic fetch_breakpoint;
  logic [1:0] cp_handshake_decode;
  logic [1:0] cp_handshake_execute;
  logic wait_state_enable;
  logic debug_tick_enable;
  modport core (
    output fetch_address, fetch_request_n, fetch_sequential, fetch_mode,
    output fetch_privileged, compressed_state, cond_pass, late_cancel_a,
    output data_request_n, data_sequential, state_advance_out,
    input fetch_data, fetch_abort, fetch_breakpoint,
    input cp_handshake_decode, cp_handshake_execute,
    input wait_state_enable, debug_tick_enable
  );
  modport sys (
    input fetch_address, fetch_request_n, fetch_sequential, fetch_mode,
    input fetch_privileged, compressed_state, cond_pass, late_cancel_a,
    input data_request_n, data_sequential, state_advance_out,
    output fetch_data, fetch_abort, fetch_breakpoint,
    output cp_handshake_decode, cp_handshake_execute,
    output wait_state_enable, debug_tick_enable
  );
endinterface

// ---- rtl/cfp_core.sv ----
// Core fetch port: fetch sequencing, condition skip, coprocessor absent.
// Assumes the memory side answers one cycle after each request.
//
// Notes on behaviour
// R1: Unclaimed coprocessor op becomes undefined instruction
// R2: Coprocessors idle at absent unless handling op
// R3: Coprocessor ops only in 32-bit state
// R4: Absent decode: internal cycle, then fetch 0x4
// R5: Then sequential 0x8, 0xC, data idle, cancel 0
// R6: Wait holds pc+3i until execute absent
// R7: Failed condition skips in one cycle
// R8: Skip cycle fetches sequential, no data access
// R9: Outputs from rising edge, inputs sampled there
// R10: Stretched clock phases lose no state
// R11: Low wait-state enable freezes whole cycle
// R12: State advance out wired straight to in
// R13: Debug timed by clock and tick enable; ticks_r also waits on the advance enable
// R14: Fetch address bits 31 to 1
// R15: Fetch abort marks fetched word aborted
// R16: Instructions return on 32-bit data bus
// R17: Breakpoint acts only if instruction executes
// R18: Low request-not means access next cycle
// R19: Mode output valid with fetch address
// R20: Privilege low in user, high otherwise
// R21: Sequential high means next fetch follows
// R22: Compressed-state output high in 16-bit state
// R23: Cycle type from request-not and sequential
`timescale 1ns/10ps
module cfp_core
  import cfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  cfp_if.core bus,
  input wire logic state_advance_in,
  input wire logic cmp_in,
  output logic [31:0] exec_fetch_data,
  output logic exec_valid,
  output logic exec_aborted,
  output logic undef_taken,
  output logic debug_entered,
  output logic [7:0] debug_ticks
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    CFP_RUN, CFP_CP_WAIT, CFP_CP_ABS, CFP_VEC_N, CFP_VEC_S1, CFP_VEC_S2
  } cfp_st_t;

  cfp_st_t st_r, st_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic [31:0] exec_fetch_data_r;
  logic exec_valid_r, exec_aborted_r, exec_bkpt_r;
  logic [4:0] mode_r;
  logic cmp_r;
  logic req_n_r, seq_r, pass_r, dreq_n_r, data_sequential_r, adv_r;
  logic undef_r, dbg_r;
  logic [7:0] ticks_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire adv = state_advance_in;  // R12
  wire [3:0] cond = exec_fetch_data_r[31:28];
  wire cond_ok = (cond == 4'hE) || (cond == 4'hF) || !cond[0];
  wire is_cp = exec_valid_r && !cmp_r
    && (exec_fetch_data_r[27:26] == 2'b11)
    && !(exec_fetch_data_r[25:24] == 2'b11);  // R3
  wire skip = exec_valid_r && !cond_ok;  // R7
  wire run_cp = is_cp && !skip;
  wire bkpt_hit = exec_valid_r && exec_bkpt_r && !skip;  // R17
  wire [1:0] hs_d = bus.cp_handshake_decode;
  wire [1:0] hs_e = bus.cp_handshake_execute;
  wire [31:0] step = cmp_r ? 32'h0000_0002 : 32'h0000_0004;
  wire [31:0] pc_seq = pc_r + step;

  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    unique case (st_r)
      CFP_RUN: begin
        pc_nxt = pc_seq;  // R8
        if (run_cp && hs_d == `CFP_HS_ABSENT) begin
          st_nxt = CFP_CP_ABS;  // R1 R4
          pc_nxt = pc_r;
        end else if (run_cp && hs_d == `CFP_HS_WAIT) begin
          st_nxt = CFP_CP_WAIT;  // R6
          pc_nxt = pc_r;
        end
      end
      CFP_CP_WAIT: begin
        if (hs_e == `CFP_HS_ABSENT) begin
          st_nxt = CFP_VEC_N;  // R6
        end else if (hs_e == `CFP_HS_LAST) begin
          st_nxt = CFP_RUN;
          pc_nxt = pc_seq;
        end
      end
      CFP_CP_ABS: st_nxt = CFP_VEC_N;  // R4
      CFP_VEC_N: begin
        st_nxt = CFP_VEC_S1;
        pc_nxt = `CFP_UNDEF_VEC2;  // R5
      end
      CFP_VEC_S1: begin
        st_nxt = CFP_VEC_S2;
        pc_nxt = `CFP_UNDEF_VEC3;  // R5
      end
      CFP_VEC_S2: begin
        st_nxt = CFP_RUN;
        pc_nxt = pc_seq;
      end
      default: st_nxt = CFP_RUN;
    endcase
  end

  // Next cycle type, per the state being entered
  wire nx_int = (st_nxt == CFP_CP_ABS) || (st_nxt == CFP_CP_WAIT);
  wire nx_n = (st_nxt == CFP_VEC_N);
  wire [31:0] fa_nxt = nx_n ? `CFP_UNDEF_VEC : pc_nxt;
  wire pass_nxt = (st_nxt == CFP_CP_ABS)
    || (st_nxt == CFP_CP_WAIT && st_r == CFP_RUN);  // R4

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Every update but adv_r waits on the advance enable, so a held or
  // stretched clock leaves all other state where it was.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= CFP_RUN;
      pc_r <= `CFP_RESET_VEC;
      exec_fetch_data_r <= 32'h0000_0000;
      exec_valid_r <= 1'b0;
      exec_aborted_r <= 1'b0;
      exec_bkpt_r <= 1'b0;
      mode_r <= `CFP_MODE_SVC;
      cmp_r <= 1'b0;
      req_n_r <= 1'b0;
      seq_r <= 1'b0;
      pass_r <= 1'b0;
      dreq_n_r <= 1'b1;
      data_sequential_r <= 1'b0;
      undef_r <= 1'b0;
      dbg_r <= 1'b0;
      ticks_r <= 8'h00;
    end else if (adv) begin  // R9 R10 R11
      st_r <= st_nxt;
      pc_r <= nx_n ? `CFP_UNDEF_VEC : pc_nxt;
      req_n_r <= nx_int;  // R18 R23
      seq_r <= !nx_int && !nx_n;  // R21 R23
      pass_r <= pass_nxt;
      dreq_n_r <= 1'b1;  // R5 R8
      data_sequential_r <= 1'b0;
      undef_r <= nx_n;
      dbg_r <= bkpt_hit;  // R17
      if (nx_n) begin
        mode_r <= `CFP_MODE_UND;
        cmp_r <= 1'b0;
      end else if (st_r == CFP_RUN && !is_cp) begin
        cmp_r <= cmp_in;  // R22
      end
      if (!req_n_r) begin
        exec_fetch_data_r <= bus.fetch_data;  // R16
        exec_aborted_r <= bus.fetch_abort;  // R15
        exec_bkpt_r <= bus.fetch_breakpoint;
        exec_valid_r <= (st_nxt == CFP_RUN) && !bus.fetch_abort;
      end else begin
        exec_valid_r <= 1'b0;
      end
      if (bus.debug_tick_enable) begin
        ticks_r <= ticks_r + 8'h01;  // R13
      end
    end
  end

  // Registered enable out; the integrator loops it back
  always_ff @(posedge clk) begin
    if (rst) begin
      adv_r <= 1'b1;
    end else begin
      adv_r <= bus.wait_state_enable;  // R11 R12
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.fetch_address = pc_r[31:1];  // R14
  assign bus.fetch_request_n = req_n_r;
  assign bus.fetch_sequential = seq_r;
  assign bus.fetch_mode = mode_r;  // R19
  assign bus.fetch_privileged = (mode_r != `CFP_MODE_USER);  // R20
  assign bus.compressed_state = cmp_r;  // R22
  assign bus.cond_pass = pass_r;
  assign bus.late_cancel_a = 1'b0;  // R5
  assign bus.data_request_n = dreq_n_r;
  assign bus.data_sequential = data_sequential_r;
  assign bus.state_advance_out = adv_r;
  assign exec_fetch_data = exec_fetch_data_r;
  assign exec_valid = exec_valid_r;
  assign exec_aborted = exec_aborted_r;
  assign undef_taken = undef_r;
  assign debug_entered = dbg_r;
  assign debug_ticks = ticks_r;
endmodule

// ---- rtl/cfp_sys.sv ----
// Memory and coprocessor end: serves fetches, drives handshakes.
// Assumes the core samples all inputs on the rising edge.
`timescale 1ns/10ps
module cfp_sys
  import cfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  cfp_if.sys bus,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_fault,
  input wire logic bkpt_req,
  input wire logic stall_req,
  input wire logic tick_req,
  input wire logic cp_claim,
  input wire logic [1:0] cp_dec_code,
  input wire logic [1:0] cp_exe_code,
  output logic [31:1] mem_addr,
  output logic mem_read
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] data_r;
  logic abort_r, bkpt_r, en_r, tick_r, rd_r;
  logic [1:0] hsd_r, hse_r;
  logic [31:1] addr_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      data_r <= 32'h0000_0000;
      abort_r <= 1'b0;
      bkpt_r <= 1'b0;
      en_r <= 1'b1;
      tick_r <= 1'b0;
      hsd_r <= `CFP_HS_ABSENT;
      hse_r <= `CFP_HS_ABSENT;
      addr_r <= 31'h0000_0000;
      rd_r <= 1'b0;
    end else begin
      en_r <= !stall_req;  // R11
      tick_r <= tick_req;
      if (bus.state_advance_out) begin
        rd_r <= !bus.fetch_request_n;
        addr_r <= bus.fetch_address;
        data_r <= mem_rdata;  // R16
        abort_r <= mem_fault;  // R15
        bkpt_r <= bkpt_req;
        // Idle at absent unless claiming the op
        hsd_r <= cp_claim ? cp_dec_code : `CFP_HS_ABSENT;  // R2
        hse_r <= cp_claim ? cp_exe_code : `CFP_HS_ABSENT;  // R2
      end
    end
  end

  assign bus.fetch_data = data_r;
  assign bus.fetch_abort = abort_r;
  assign bus.fetch_breakpoint = bkpt_r;
  assign bus.wait_state_enable = en_r;
  assign bus.debug_tick_enable = tick_r;
  assign bus.cp_handshake_decode = hsd_r;
  assign bus.cp_handshake_execute = hse_r;
  assign mem_addr = addr_r;
  assign mem_read = rd_r;
endmodule

// ---- sim/cfp_checker.sv ----
// Assertions on the wires between core end and system end.
// Assumes one clock, sync reset, placed beside cfp_if.
`timescale 1ns/10ps
`include "cfp_defs.svh"
module cfp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:1] fetch_address,
  input wire logic fetch_request_n,
  input wire logic fetch_sequential,
  input wire logic [4:0] fetch_mode,
  input wire logic fetch_privileged,
  input wire logic compressed_state,
  input wire logic cond_pass,
  input wire logic late_cancel_a,
  input wire logic data_request_n,
  input wire logic data_sequential,
  input wire logic state_advance_out,
  input wire logic wait_state_enable
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire vec_n = !fetch_request_n && !fetch_sequential && fetch_address == 31'h2;
  wire req = !fetch_request_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_cancel_low: assert property (!late_cancel_a)
    else $error("late cancel high");
  chk_data_idle: assert property (data_request_n && !data_sequential)
    else $error("data access seen");
  chk_vec_entry: assert property (
    vec_n && $past(state_advance_out) |-> !cond_pass && $past(fetch_request_n))
    else $error("vector fetch without internal cycle");
  chk_vec_next: assert property (
    vec_n && state_advance_out |=> req && fetch_sequential
    && fetch_address == 31'h4)
    else $error("no sequential fetch after vector");
  chk_seq_step: assert property (
    (req && state_advance_out) ##1 (req && fetch_sequential) |->
    fetch_address == $past(fetch_address)
    + ($past(compressed_state) ? 31'h1 : 31'h2))
    else $error("sequential address step");
  chk_wait_hold: assert property (
    fetch_request_n && $past(fetch_request_n) |-> $stable(fetch_address))
    else $error("address moved in internal run");
  chk_stall_hold: assert property (
    !state_advance_out |=> $stable(fetch_address)
    && $stable(fetch_request_n) && $stable(cond_pass))
    else $error("state moved while stalled");
  chk_adv_follow: assert property (
    1'b1 |=> state_advance_out == $past(wait_state_enable))
    else $error("advance not following wait enable");
  chk_priv_mode: assert property (
    fetch_privileged == (fetch_mode != `CFP_MODE_USER))
    else $error("privilege mismatch");
  cov_vec: cover property (vec_n && state_advance_out);
  cov_stall: cover property (!state_advance_out);
  cov_wait: cover property (fetch_request_n [*3]);
endmodule

// ---- sim/tb_core_fetch_port_cp_absent.sv ----
// Bench joining both fetch port ends; memory served from an address pattern and an LFSR.
// Assumes the design files and cfp_defs.svh on the include path.
`timescale 1ns/10ps
`include "cfp_defs.svh"
module tb_core_fetch_port_cp_absent
  import cfp_pkg::*;
;
  logic clk, rst, cmp_in, mem_fault, bkpt_req, stall_req, tick_req;
  logic cp_claim, mem_read, undef_taken;
  logic [1:0] cp_dec_code, cp_exe_code;
  logic [31:0] mem_rdata, lfsr;
  logic [31:1] mem_addr;
  logic [31:0] exp_q[$];
  int mismatches, samples_checked, cycles, phase, idle_run;
  cfp_if bus_if();
  cfp_core i_cfp_core(.clk, .rst, .bus(bus_if), .cmp_in, .undef_taken,
    .state_advance_in(bus_if.state_advance_out), .exec_fetch_data(),
    .exec_valid(), .exec_aborted(), .debug_entered(), .debug_ticks());
  cfp_sys i_cfp_sys(.clk, .rst, .bus(bus_if), .mem_rdata, .mem_fault,
    .bkpt_req, .stall_req, .tick_req, .cp_claim, .cp_dec_code,
    .cp_exe_code, .mem_addr, .mem_read);
  cfp_checker i_cfp_checker(.clk, .rst,
    .fetch_address(bus_if.fetch_address),
    .fetch_request_n(bus_if.fetch_request_n),
    .fetch_sequential(bus_if.fetch_sequential),
    .fetch_mode(bus_if.fetch_mode),
    .fetch_privileged(bus_if.fetch_privileged),
    .compressed_state(bus_if.compressed_state),
    .cond_pass(bus_if.cond_pass), .late_cancel_a(bus_if.late_cancel_a),
    .data_request_n(bus_if.data_request_n),
    .data_sequential(bus_if.data_sequential),
    .state_advance_out(bus_if.state_advance_out),
    .wait_state_enable(bus_if.wait_state_enable));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, stimulus, watcher
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One op per 64 bytes, so any start address meets one; rest fail cond
  always @(negedge clk) begin
    lfsr <= lfsr_next(lfsr);
    stall_req <= phase == 3 && lfsr[1:0] == 2'b00;
    tick_req <= lfsr[7];
    mem_rdata <= (mem_addr[5:2] == 4'h0) ? 32'hEE00_0000
      : {8'h10, lfsr[31:8]};
    idle_run <= bus_if.fetch_request_n ? idle_run + 1 : 0;
    // Wait must already stand when the core enters its wait loop
    cp_exe_code <= (phase == 2 && idle_run < 3)
      ? CFP_HS_WAIT_E : CFP_HS_ABSENT_E;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
    // A stalled cycle shows the same pulse again; count it once
    if (!rst && undef_taken === 1'b1 && bus_if.state_advance_out === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0000_0000, 32'h0000_0004);
      else check({bus_if.fetch_address, 1'b0}, exp_q.pop_front());
      check({27'h0, bus_if.fetch_mode}, {27'h0, `CFP_MODE_UND});
      check({30'h0, bus_if.fetch_request_n, bus_if.fetch_sequential},
        32'h0000_0000);
    end
  end
  initial begin
    {rst, cmp_in, mem_fault, bkpt_req, stall_req, tick_req} = 6'h21;
    {cp_claim, cp_dec_code, cp_exe_code, phase, cycles, idle_run} = '0;
    {mismatches, samples_checked} = '0;
    mem_rdata = 32'h0000_0000;
    lfsr = 32'h0001_586C;
    repeat (6) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    // Absent decode, compressed state, decode wait, stalled absent
    for (int p = 0; p < 4; p++) begin
      @(negedge clk);
      phase = p;
      cmp_in = p == 1;
      cp_claim = p == 2;
      cp_dec_code = (p == 2) ? CFP_HS_WAIT_E : CFP_HS_ABSENT_E;
      if (p == 1) repeat (300) @(posedge clk);
      else exp_q.push_back(32'h0000_0004);
      for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) check(32'h0000_0000, 32'h0000_0004);
    end
    report_and_stop();
  end
endmodule
